//--- lem_pkg.sv
`default_nettype none
package lem_pkg;
    // ****************************************************************
    // register offsets (byte addresses on the internal bus)
    // ****************************************************************
    localparam logic [7:0] LEM_OFF_MONITOR = 8'h04;  // bus monitor
    localparam logic [7:0] LEM_OFF_HBERR   = 8'h08;  // host bus error
    localparam logic [7:0] LEM_OFF_FWIRQ   = 8'h0C;  // firmware irq
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int LEM_B_PDSTATE  = 0;   // power-down state bit
    localparam int LEM_B_ANY      = 0;   // combined fault flag
    localparam int LEM_B_EN       = 1;   // internal-error enable
    localparam int LEM_B_BAR      = 2;   // bar conflict flag
    localparam int LEM_B_RUN      = 3;   // runtime i/o fault flag
    localparam int LEM_B_CFG      = 4;   // configuration fault flag
    localparam int LEM_B_DMA      = 5;   // dma fault flag
    localparam int LEM_B_ADDR_LO  = 8;   // fault address low bit
    localparam int LEM_ADDR_W     = 24;  // fault address width
    localparam int LEM_B_FWIRQ    = 0;   // firmware irq bit
    localparam logic [31:0] LEM_RST_VAL = 32'h0000_0000; // reset value
    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic                  valid;    // one transaction ended
        logic [LEM_ADDR_W-1:0] addr;     // its internal address
        logic                  bar_hit2; // two or more bars matched
        logic                  dma_err;  // dma access bus error
        logic                  cfg_err;  // config access bus error
        logic                  io_err;   // i/o access bus error
    } lem_txn_t;
    typedef struct packed {
        logic        rd;     // read strobe
        logic        wr;     // write strobe
        logic [7:0]  addr;   // byte offset
        logic [31:0] wdata;  // write data
    } lem_req_t;
endpackage : lem_pkg
`default_nettype wire

//--- lem_w1c_bit.sv
`default_nettype none
// sticky flag: hardware set wins over software write-one clear
module lem_w1c_bit
    import lem_pkg::*;
(
    input  wire logic SYS_CLK,
    input  wire logic RST_N,
    input  wire logic set_i,
    input  wire logic clr_i,
    output var  logic flag_o
);
    logic flag_q;  // stored flag
    logic flag_d;  // next flag
    // ****************************************************************
    // next value
    // ****************************************************************
    always_comb begin
        flag_d = flag_q;
        if (clr_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;  // set has priority
        end
    end
    // register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag_o = flag_q;
endmodule : lem_w1c_bit
`default_nettype wire

//--- lem_regs.sv
`default_nettype none
module lem_regs
    import lem_pkg::*;
(
    input  wire logic     SYS_CLK,
    input  wire logic     RST_N,
    input  wire logic     POWER_DOWN_N,
    input  wire lem_txn_t TXN,
    input  wire lem_req_t REQ,
    output var  logic     RD_VALID,
    output var  logic [31:0] RDATA,
    output var  logic     FAULT_IRQ,
    output var  logic     FW_IRQ_SOURCE
);
    // number of bits in the flag and enable group of the error register
    localparam int LEM_NFLAG = LEM_B_DMA + 1;
    // every property below runs on the system clock, off during reset
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    // ****************************************************************
    // state
    // ****************************************************************
    logic                  pd_q, pd_d;           // power-down state
    logic [LEM_ADDR_W-1:0] addr_q, addr_d;       // fault_addr
    logic                  en_q, en_d;           // internal-error enable
    logic                  fw_q, fw_d;           // fw_irq_source
    logic                  rv_q, rv_d;           // read answer valid
    logic [31:0]           rd_q, rd_d;           // read data
    logic [LEM_NFLAG-1:0]  set_v;                // flag set terms
    logic [LEM_NFLAG-1:0]  clr_v;                // flag clear terms
    logic [LEM_NFLAG-1:0]  flag_v;               // flag values
    logic                  bus_fault;            // enabled bus error now
    logic                  wr_err;               // write to hbe reg
    // address decode shared by read and write paths
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit
    // ****************************************************************
    // flag set and clear terms
    // ****************************************************************
    always_comb begin
        wr_err = REQ.wr && hit(REQ.addr, LEM_OFF_HBERR);
        bus_fault = TXN.valid && en_q &&
                    (TXN.dma_err || TXN.cfg_err || TXN.io_err);
        set_v = '0;
        set_v[LEM_B_DMA] = TXN.valid && en_q && TXN.dma_err;
        set_v[LEM_B_CFG] = TXN.valid && en_q && TXN.cfg_err;
        set_v[LEM_B_RUN] = TXN.valid && en_q && TXN.io_err;
        set_v[LEM_B_BAR] = TXN.valid && TXN.bar_hit2;
        // conflict always, bus errors only when enabled
        set_v[LEM_B_ANY] = (TXN.valid && TXN.bar_hit2) || bus_fault;
        clr_v = '0;
        for (int i = 0; i < LEM_NFLAG; i++) begin
            if (i != LEM_B_EN) begin
                clr_v[i] = wr_err && REQ.wdata[i];
            end
        end
    end
    // ****************************************************************
    // sticky flags, one instance per w1c bit
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < LEM_NFLAG; g++) begin : g_flag
            if (g == LEM_B_EN) begin : g_rw
                assign flag_v[g] = en_q;
            end else begin : g_w1c
                lem_w1c_bit u_bit (
                    .SYS_CLK (SYS_CLK),
                    .RST_N   (RST_N),
                    .set_i   (set_v[g]),
                    .clr_i   (clr_v[g]),
                    .flag_o  (flag_v[g])
                );
            end
        end
    endgenerate
    // ****************************************************************
    // next values of plain registers
    // ****************************************************************
    always_comb begin
        pd_d   = ~POWER_DOWN_N;
        addr_d = addr_q;
        // load only while combined flag clear: first fault kept
        if (TXN.valid && !flag_v[LEM_B_ANY]) begin
            addr_d = TXN.addr;
        end
        en_d = en_q;
        if (wr_err) begin
            en_d = REQ.wdata[LEM_B_EN];
        end
        fw_d = fw_q;
        if (REQ.wr && hit(REQ.addr, LEM_OFF_FWIRQ)) begin
            fw_d = REQ.wdata[LEM_B_FWIRQ];
        end
        rv_d = REQ.rd;
        rd_d = LEM_RST_VAL;
        if (REQ.rd) begin
            if (hit(REQ.addr, LEM_OFF_MONITOR)) begin
                rd_d[LEM_B_PDSTATE] = pd_q;
            end else if (hit(REQ.addr, LEM_OFF_HBERR)) begin
                rd_d[31:LEM_B_ADDR_LO] = addr_q;
                rd_d[LEM_NFLAG-1:0] = flag_v;
            end else if (hit(REQ.addr, LEM_OFF_FWIRQ)) begin
                rd_d[LEM_B_FWIRQ] = fw_q;
            end
        end
    end
    // register stage; internal bus only
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pd_q   <= 1'b0;
            addr_q <= '0;
            en_q   <= 1'b0;
            fw_q   <= 1'b0;
            rv_q   <= 1'b0;
            rd_q   <= LEM_RST_VAL;
        end else begin
            pd_q   <= pd_d;
            addr_q <= addr_d;
            en_q   <= en_d;
            fw_q   <= fw_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
        end
    end
    assign RD_VALID      = rv_q;
    assign RDATA         = rd_q;
    assign FAULT_IRQ     = flag_v[LEM_B_ANY];
    assign FW_IRQ_SOURCE = fw_q;
    // ****************************************************************
    // assertions
    // ****************************************************************
    // a finished transaction on which two or more bars matched
    sequence s_conflict;
        TXN.valid && TXN.bar_hit2;
    endsequence
    // a finished transaction that ran into an internal bus error
    sequence s_bus_error;
        TXN.valid && (TXN.dma_err || TXN.cfg_err || TXN.io_err);
    endsequence
    // software writes the error register
    sequence s_err_write;
        REQ.wr && (REQ.addr == LEM_OFF_HBERR);
    endsequence
    // software writes the firmware irq register
    sequence s_fw_write;
        REQ.wr && (REQ.addr == LEM_OFF_FWIRQ);
    endsequence
    // power-down state follows the inverted pin one cycle later
    AST_PD_INV: assert property (
        ##1 pd_q == !$past(POWER_DOWN_N))
        else $error("power-down state not inverse of pin");
    // address follows every transaction while no fault is held
    AST_ADDR_LOAD: assert property (
        TXN.valid && !flag_v[LEM_B_ANY] |=> addr_q == $past(TXN.addr))
        else $error("fault address not loaded");
    // a held fault freezes the address field
    AST_ADDR_HOLD: assert property (
        flag_v[LEM_B_ANY] |=> $stable(addr_q))
        else $error("fault address moved while held");
    // first failing transaction leaves its address and raises the flag
    AST_FIRST_KEPT: assert property (
        s_bus_error ##0 (en_q && !flag_v[LEM_B_ANY])
        |=> flag_v[LEM_B_ANY] && addr_q == $past(TXN.addr))
        else $error("first failing address not kept");
    AST_DMA_SET: assert property (
        s_bus_error ##0 (en_q && TXN.dma_err) |=> flag_v[LEM_B_DMA])
        else $error("dma flag not set");
    AST_CFG_SET: assert property (
        s_bus_error ##0 (en_q && TXN.cfg_err) |=> flag_v[LEM_B_CFG])
        else $error("configuration flag not set");
    AST_IO_SET: assert property (
        s_bus_error ##0 (en_q && TXN.io_err) |=> flag_v[LEM_B_RUN])
        else $error("i/o flag not set");
    AST_BAR_SET: assert property (
        s_conflict |=> flag_v[LEM_B_BAR] && flag_v[LEM_B_ANY])
        else $error("conflict not flagged");
    // with reporting off, bus errors set neither the i/o nor the any flag
    AST_IO_GATE: assert property (
        !flag_v[LEM_B_RUN] && !en_q |=> !flag_v[LEM_B_RUN])
        else $error("i/o flag set while reporting off");
    AST_ANY_GATE: assert property (
        !flag_v[LEM_B_ANY] && !en_q && !(TXN.valid && TXN.bar_hit2)
        |=> !flag_v[LEM_B_ANY])
        else $error("combined flag set without conflict");
    AST_ANY_SET: assert property (
        s_bus_error ##0 en_q |=> flag_v[LEM_B_ANY])
        else $error("combined flag not set on bus error");
    // a flag survives any write that does not hold a one in its bit
    AST_W1C: assert property (
        flag_v[LEM_B_BAR] && !(wr_err && REQ.wdata[LEM_B_BAR])
        |=> flag_v[LEM_B_BAR])
        else $error("conflict flag lost");
    // a one written with no conflict in the same cycle clears the flag
    AST_W1C_CLR: assert property (
        s_err_write ##0 (REQ.wdata[LEM_B_BAR] &&
            !(TXN.valid && TXN.bar_hit2))
        |=> !flag_v[LEM_B_BAR])
        else $error("conflict flag not cleared");
    // the interrupt level rises only after a qualifying cause
    AST_IRQ: assert property (
        !FAULT_IRQ ##1 FAULT_IRQ
        |-> $past(TXN.valid && (TXN.bar_hit2 || (en_q && (TXN.dma_err ||
            TXN.cfg_err || TXN.io_err)))))
        else $error("interrupt without a cause");
    // the firmware irq bit takes the written value and then holds
    AST_FW_WRITE: assert property (
        s_fw_write |=> FW_IRQ_SOURCE == $past(REQ.wdata[LEM_B_FWIRQ]))
        else $error("firmware irq bit not written");
    AST_FW_HOLD: assert property (
        !(REQ.wr && REQ.addr == LEM_OFF_FWIRQ) |=> $stable(FW_IRQ_SOURCE))
        else $error("firmware irq bit moved");
    // every internal bus read is answered exactly one cycle later
    AST_RD_ANS: assert property (
        REQ.rd |=> RD_VALID)
        else $error("read not answered");
    // read data stays zero outside an answer
    AST_RD_IDLE: assert property (
        !REQ.rd |=> !RD_VALID && RDATA == '0)
        else $error("read data shown without a read");
    // gap between flags and address always reads zero
    AST_RSV_ZERO: assert property (
        RD_VALID |-> RDATA[LEM_B_ADDR_LO-1:LEM_NFLAG] == '0)
        else $error("reserved bits not zero");
endmodule : lem_regs
`default_nettype wire

//--- lem_host_model.sv
`default_nettype none
// ****************************************************************
// host side: reports finished lpc transactions to the block
// ****************************************************************
module lem_host_model
    import lem_pkg::*;
(
    input  wire logic     SYS_CLK,
    output var  lem_txn_t TXN
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero
    initial begin
        TXN = '0;
    end

    // one transaction, e = {bar_hit2, dma, cfg, io}
    task automatic send(input logic [23:0] a, input logic [3:0] e);
        @(posedge SYS_CLK);
        #1;
        TXN = {1'b1, a, e};
        @(posedge SYS_CLK);
        #1;
        // released fields show junk, only valid high qualifies them
        TXN = {1'b0, ~a, ~e};
    endtask : send
endmodule : lem_host_model
`default_nettype wire

//--- tb_lem_regs.sv
`default_nettype none
// ****************************************************************
// register bank bench
// ****************************************************************
module tb_lem_regs
    import lem_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;        // system clock
    logic        rst_n;      // sync reset
    logic        pd_n;       // power-down pin
    lem_txn_t    txn;        // from host model
    lem_req_t    req;        // internal bus request
    logic        rd_valid;   // read answer strobe
    logic [31:0] rdata;      // read data
    logic        fault_irq;  // combined fault level
    logic        fw_irq;     // firmware irq level
    int          fail_count; // mismatches
    int          n_compared; // comparisons

    lem_host_model u_host (.SYS_CLK(clk), .TXN(txn));
    lem_regs u_dut (.SYS_CLK(clk), .RST_N(rst_n), .POWER_DOWN_N(pd_n),
        .TXN(txn), .REQ(req), .RD_VALID(rd_valid), .RDATA(rdata),
        .FAULT_IRQ(fault_irq), .FW_IRQ_SOURCE(fw_irq));

    // compare one value
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
    endtask : wr

    // one-cycle read strobe, answer one cycle later
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        #1;
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        chk("rd_valid", 32'h1, {31'h0, rd_valid});
        chk("rdata", e, rdata);
        // answer stands one cycle only, then data returns to zero
        @(posedge clk);
        #1;
        chk("rd_valid_idle", 32'h0, {31'h0, rd_valid});
        chk("rdata_idle", 32'h0, rdata);
    endtask : rd

    // verdict and end of run
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog, tests need well under 400 cycles
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    // test sequence
    initial begin
        fail_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        pd_n = 1'b1;
        req = '0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd(LEM_OFF_MONITOR, 32'h0);
        rd(LEM_OFF_HBERR, 32'h0);
        rd(LEM_OFF_FWIRQ, 32'h0);
        u_host.send(24'h12_3456, 4'h0);
        rd(LEM_OFF_HBERR, 32'h1234_5600);
        u_host.send(24'hAB_CDEF, 4'h4);
        rd(LEM_OFF_HBERR, 32'hABCD_EF00);
        wr(LEM_OFF_HBERR, 32'h0000_0002);
        u_host.send(24'h11_1111, 4'h1);
        rd(LEM_OFF_HBERR, 32'h1111_110B);
        chk("fault_irq", 32'h1, {31'h0, fault_irq});
        u_host.send(24'h22_2222, 4'h2);
        rd(LEM_OFF_HBERR, 32'h1111_111B);
        u_host.send(24'h33_3333, 4'h4);
        rd(LEM_OFF_HBERR, 32'h1111_113B);
        wr(LEM_OFF_HBERR, 32'h0000_0002);
        rd(LEM_OFF_HBERR, 32'h1111_113B);
        wr(LEM_OFF_HBERR, 32'hFFFF_003F);
        rd(LEM_OFF_HBERR, 32'h1111_1102);
        chk("fault_irq", 32'h0, {31'h0, fault_irq});
        wr(LEM_OFF_HBERR, 32'h0000_0001);
        u_host.send(24'h44_4444, 4'h9);
        rd(LEM_OFF_HBERR, 32'h4444_4405);
        wr(LEM_OFF_HBERR, 32'h0000_0005);
        rd(LEM_OFF_HBERR, 32'h4444_4400);
        // conflict and its clear land on one edge: the set wins
        fork
            u_host.send(24'h55_5555, 4'h8);
            wr(LEM_OFF_HBERR, 32'h0000_0005);
        join
        rd(LEM_OFF_HBERR, 32'h5555_5505);
        wr(LEM_OFF_HBERR, 32'h0000_0005);
        rd(LEM_OFF_HBERR, 32'h5555_5500);
        // config and i/o errors with reporting off leave no flag
        u_host.send(24'h77_7777, 4'h3);
        rd(LEM_OFF_HBERR, 32'h7777_7700);
        pd_n = 1'b0;
        repeat (2) @(posedge clk);
        rd(LEM_OFF_MONITOR, 32'h1);
        pd_n = 1'b1;
        repeat (2) @(posedge clk);
        rd(LEM_OFF_MONITOR, 32'h0);
        wr(LEM_OFF_FWIRQ, 32'hFFFF_FFFF);
        rd(LEM_OFF_FWIRQ, 32'h1);
        chk("fw_irq", 32'h1, {31'h0, fw_irq});
        wr(LEM_OFF_MONITOR, 32'hFFFF_FFFF);
        rd(LEM_OFF_MONITOR, 32'h0);
        rd(8'h10, 32'h0);
        wr(LEM_OFF_FWIRQ, 32'h0);
        chk("fw_irq", 32'h0, {31'h0, fw_irq});
        // mid-run reset clears enable, flags, address and irq bit
        wr(LEM_OFF_FWIRQ, 32'h1);
        wr(LEM_OFF_HBERR, 32'h0000_0002);
        u_host.send(24'h66_6666, 4'h2);
        chk("fault_irq", 32'h1, {31'h0, fault_irq});
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("fault_irq", 32'h0, {31'h0, fault_irq});
        chk("fw_irq", 32'h0, {31'h0, fw_irq});
        rd(LEM_OFF_HBERR, 32'h0);
        rd(LEM_OFF_FWIRQ, 32'h0);
        complete_run();
    end
endmodule : tb_lem_regs
`default_nettype wire
